// file: inc/fcd_pkg.sv
// Purpose: shared constants, types and helpers of the four channel transfer_controller
// Assumes: byte wide data space with 16 bit addresses, one clock, synchronous reset
// Notes: channel configuration arrives on plain ports; no software visible registers
// Contract
// - four channels, each configured independently
// - block length from 1 byte to 64K
// - repeat count reruns block, up to 256
// - source, destination: increment, decrement or fixed
// - optional address reload when transaction completes
// - burst of 1, 2, 4 or 8 bytes
// - software programmable channel priority
// - transfers use the processor's shared data bus
// - paired channels hand over on completion, alternating
// - non-volatile memory read only; program memory never
// - triggers: peripheral, event, software; per channel set
// - peripherals reached through their mapped registers
// - memory and peripheral both ends, any combination
// - processor wins bus, deterministic, nothing corrupted
package fcd_pkg;

  localparam int FCD_NCH        = 4;
  localparam int FCD_AW         = 16;
  localparam int FCD_DW         = 8;
  localparam int FCD_NTRIG      = 16;
  localparam int FCD_FIFO_DEPTH = 16;
  localparam int FCD_MAX_BURST  = 8;

  // regions of the data space the engine must respect
  localparam logic [15:0] FCD_NVM_BASE  = 16'h1000;
  localparam logic [15:0] FCD_NVM_LAST  = 16'h17FF;
  localparam logic [15:0] FCD_PROG_BASE = 16'hF000;
  localparam logic [15:0] FCD_PROG_LAST = 16'hFFFF;

  // values after reset
  localparam logic [15:0] FCD_RST_ADDR = 16'h0000;
  localparam logic [16:0] FCD_RST_BLK  = 17'h00000;
  localparam logic [8:0]  FCD_RST_REP  = 9'h000;

  typedef enum logic [1:0] {
    FCD_AM_FIXED = 2'h0,
    FCD_AM_INC   = 2'h1,
    FCD_AM_DEC   = 2'h2
  } fcd_amode_e;

  // burst code n moves 2**n bytes
  typedef enum logic [1:0] {
    FCD_BL_1 = 2'h0,
    FCD_BL_2 = 2'h1,
    FCD_BL_4 = 2'h2,
    FCD_BL_8 = 2'h3
  } fcd_burst_e;

  typedef enum logic [4:0] {
    FCD_S_IDLE  = 5'h01,
    FCD_S_RD    = 5'h02,
    FCD_S_WR    = 5'h04,
    FCD_S_NEXT  = 5'h08,
    FCD_S_ABORT = 5'h10
  } fcd_state_e;

  // per channel configuration, block size 0 means 64K, repeat 0 means 256
  typedef struct packed {
    logic [15:0] src_addr;
    logic [15:0] dst_addr;
    logic [15:0] blk_size;
    logic [7:0]  rep_cnt;
    fcd_amode_e  src_mode;
    fcd_amode_e  dst_mode;
    fcd_burst_e  burst;
    logic        reload;
    logic        link;
    logic        irq_en;
    logic [3:0]  trig_sel;
  } fcd_cfg_s;

  typedef struct packed {
    logic        active;
    logic        pend;
    logic        done;
    logic        err;
    logic [15:0] src;
    logic [15:0] dst;
    logic [16:0] blk_left;
    logic [8:0]  rep_left;
  } fcd_chan_s;

  // request onto the shared data bus
  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } fcd_bus_req_s;

  function automatic logic [15:0] fcd_step(input logic [15:0] a, input fcd_amode_e m);
    logic [15:0] r;
    r = a;
    case (m)
      FCD_AM_INC: r = a + 16'h0001;
      FCD_AM_DEC: r = a - 16'h0001;
      default:    r = a;
    endcase
    return r;
  endfunction

  function automatic logic fcd_in_rng(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

// file: logic/fcd_fifo.sv
// Purpose: byte buffer between the read and write phases of a burst
// Assumes: single clock, synchronous active high reset
// Notes: flush empties it in one cycle, used when a burst is aborted
`timescale 1ns/1ps
module fcd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin
      $error("fcd_fifo: DEPTH must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW:0]             wp;
    logic [PW:0]             rp;
  } fcd_fifo_s;

  fcd_fifo_s st_r;
  fcd_fifo_s st_nxt;
  logic      full;
  logic      empty;
  logic      push;
  logic      pop;

  // extra pointer bit tells full from empty
  assign full        = (st_r.wp[PW] != st_r.rp[PW]) && (st_r.wp[PW-1:0] == st_r.rp[PW-1:0]);
  assign empty       = (st_r.wp == st_r.rp);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = st_r.mem[st_r.rp[PW-1:0]];
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;

  // pointer and storage update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp[PW-1:0]] = in_data_i;
      st_nxt.wp                   = st_r.wp + (PW+1)'(1);
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + (PW+1)'(1);
    end
    if (flush_i) begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // fcd_fifo

// file: logic/fcd_transfer_controller.sv
// Purpose: four channel transfer_controller moving bytes over the shared data bus
// Assumes: bus answers a request with bus_ack_i in the same cycle, read data alongside
// Notes: every burst is read into the buffer then written out; one burst in flight
`timescale 1ns/1ps
module fcd_transfer_controller
  import fcd_pkg::*;
#(
  parameter int                NCH        = FCD_NCH,
  parameter int                NTRIG      = FCD_NTRIG,
  parameter int                FIFO_DEPTH = FCD_FIFO_DEPTH,
  parameter logic [NCH*NTRIG-1:0] TRIG_AVAIL = '1,
  parameter logic [15:0]       NVM_BASE   = FCD_NVM_BASE,
  parameter logic [15:0]       NVM_LAST   = FCD_NVM_LAST,
  parameter logic [15:0]       PROG_BASE  = FCD_PROG_BASE,
  parameter logic [15:0]       PROG_LAST  = FCD_PROG_LAST
) (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire fcd_cfg_s [NCH-1:0]  cfg_i,
  input  wire logic [NCH-1:0]      addr_load_i,
  input  wire logic [NCH-1:0]      start_i,
  input  wire logic [NCH-1:0]      abort_i,
  input  wire logic [NCH-1:0]      sw_trig_i,
  input  wire logic [NTRIG-1:0]    trig_i,
  input  wire logic [NCH-1:0]      flag_clr_i,
  input  wire logic                rr_mode_i,
  input  wire logic                cpu_req_i,
  output fcd_bus_req_s             bus_o,
  input  wire logic                bus_ack_i,
  input  wire logic [7:0]          bus_rdata_i,
  output logic [NCH-1:0]           active_o,
  output logic [NCH-1:0]           done_o,
  output logic [NCH-1:0]           err_o,
  output logic                     busy_o,
  output logic                     irq_o
);
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  // linking pairs channels 2k and 2k+1, so the count must be even
  initial begin
    if (NCH < 2 || (NCH % 2) != 0 || NCH > 16) begin
      $error("fcd_transfer_controller: NCH must be even, 2..16");
    end
    if (NTRIG < 1 || NTRIG > 16) begin
      $error("fcd_transfer_controller: NTRIG must be 1..16");
    end
    // a buffer shorter than the longest burst would stall the read phase for good
    if (FIFO_DEPTH < FCD_MAX_BURST) begin
      $error("fcd_transfer_controller: FIFO_DEPTH must hold a whole burst");
    end
  end

  typedef struct packed {
    fcd_chan_s [NCH-1:0] ch;
    fcd_state_e          fsm;
    logic [CW-1:0]       cur;
    logic [CW-1:0]       rr;
    logic [3:0]          rd_left;
    logic [3:0]          wr_left;
    logic                irq;
  } fcd_top_s;

  fcd_top_s     st_r;
  fcd_top_s     st_nxt;
  logic         fifo_in_rdy;
  logic         fifo_out_vld;
  logic [7:0]   fifo_out_data;
  logic [15:0]  cur_src;
  logic [15:0]  cur_dst;
  logic         src_bad;
  logic         dst_bad;
  logic         rd_go;
  logic         wr_go;
  logic [NCH-1:0] ready;
  logic [CW:0]  sel;
  logic [CW-1:0] ci;
  logic [CW-1:0] partner;
  logic [3:0]   blen;
  logic [3:0]   len;
  logic         hw_trig;

  // first requesting channel, scanning fixed from 0 or from the round robin pointer
  function automatic logic [CW:0] pick(input logic [NCH-1:0] req, input logic [CW-1:0] rr, input logic rrm);
    logic [CW:0] res;
    int          k;
    res = '0;
    for (int i = 0; i < NCH; i++) begin
      k = rrm ? ((int'(rr) + i) % NCH) : i;
      if (!res[CW] && req[k]) begin
        res = {1'b1, CW'(k)};
      end
    end
    return res;
  endfunction

  assign cur_src = st_r.ch[st_r.cur].src;
  assign cur_dst = st_r.ch[st_r.cur].dst;

  // program memory is untouchable, non-volatile memory only readable
  assign src_bad = fcd_in_rng(cur_src, PROG_BASE, PROG_LAST);
  assign dst_bad = fcd_in_rng(cur_dst, PROG_BASE, PROG_LAST)
                 || fcd_in_rng(cur_dst, NVM_BASE, NVM_LAST);

  // the processor always wins the bus; the engine simply waits, no access is cut
  assign rd_go = (st_r.fsm == FCD_S_RD) && (st_r.rd_left != 4'h0) && fifo_in_rdy
               && !cpu_req_i && !src_bad;
  assign wr_go = (st_r.fsm == FCD_S_WR) && fifo_out_vld && !cpu_req_i && !dst_bad;

  // one shared bus for memory and peripheral registers alike
  always_comb begin
    bus_o.valid = rd_go || wr_go;
    bus_o.we    = wr_go;
    bus_o.addr  = (st_r.fsm == FCD_S_WR) ? cur_dst : cur_src;
    bus_o.wdata = fifo_out_data;
  end

  fcd_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .srst_i      (srst_i),
    .flush_i     (st_r.fsm == FCD_S_ABORT),
    .in_valid_i  (rd_go && bus_ack_i),
    .in_ready_o  (fifo_in_rdy),
    .in_data_i   (bus_rdata_i),
    .out_valid_o (fifo_out_vld),
    .out_ready_i (wr_go && bus_ack_i),
    .out_data_o  (fifo_out_data)
  );

  // channels with a trigger waiting
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ready[c] = st_r.ch[c].active && st_r.ch[c].pend;
    end
  end

  always_comb begin
    st_nxt  = st_r;
    sel     = '0;
    ci      = st_r.cur;
    partner = st_r.cur ^ CW'(1);
    blen    = 4'h1;
    len     = 4'h1;
    hw_trig = 1'b0;

    // software side: clears, address loads, starts and aborts, each channel on its own
    for (int c = 0; c < NCH; c++) begin
      if (flag_clr_i[c]) begin
        st_nxt.ch[c].done = 1'b0;
        st_nxt.ch[c].err  = 1'b0;
      end
      if (addr_load_i[c] && !st_r.ch[c].active) begin
        st_nxt.ch[c].src = cfg_i[c].src_addr;
        st_nxt.ch[c].dst = cfg_i[c].dst_addr;
      end
      if (start_i[c] && !st_r.ch[c].active) begin
        st_nxt.ch[c].active   = 1'b1;
        st_nxt.ch[c].pend     = 1'b0;
        st_nxt.ch[c].blk_left = {cfg_i[c].blk_size == 16'h0000, cfg_i[c].blk_size};
        st_nxt.ch[c].rep_left = {cfg_i[c].rep_cnt == 8'h00, cfg_i[c].rep_cnt};
      end
      // abort of the channel whose burst is in flight is ignored, not held, so a burst is never torn
      if (abort_i[c] && !(st_r.fsm != FCD_S_IDLE && st_r.cur == CW'(c))) begin
        st_nxt.ch[c].active = 1'b0;
        st_nxt.ch[c].pend   = 1'b0;
      end
    end

    case (st_r.fsm)
      FCD_S_IDLE: begin
        sel = pick(ready, st_r.rr, rr_mode_i);
        if (sel[CW]) begin
          ci   = sel[CW-1:0];
          blen = 4'h1 << cfg_i[ci].burst;
          len  = (st_r.ch[ci].blk_left < 17'(blen)) ? st_r.ch[ci].blk_left[3:0] : blen;
          st_nxt.cur          = ci;
          st_nxt.rd_left      = len;
          st_nxt.wr_left      = len;
          st_nxt.ch[ci].pend  = 1'b0;
          st_nxt.fsm          = FCD_S_RD;
        end
      end
      FCD_S_RD: begin
        if (src_bad) begin
          st_nxt.fsm = FCD_S_ABORT;
        end else if (rd_go && bus_ack_i) begin
          st_nxt.ch[st_r.cur].src = fcd_step(cur_src, cfg_i[st_r.cur].src_mode);
          st_nxt.rd_left          = st_r.rd_left - 4'h1;
          if (st_r.rd_left == 4'h1) begin
            st_nxt.fsm = FCD_S_WR;
          end
        end
      end
      FCD_S_WR: begin
        if (dst_bad) begin
          st_nxt.fsm = FCD_S_ABORT;
        end else if (wr_go && bus_ack_i) begin
          st_nxt.ch[st_r.cur].dst      = fcd_step(cur_dst, cfg_i[st_r.cur].dst_mode);
          st_nxt.ch[st_r.cur].blk_left = st_r.ch[st_r.cur].blk_left - 17'h00001;
          st_nxt.wr_left               = st_r.wr_left - 4'h1;
          if (st_r.wr_left == 4'h1) begin
            st_nxt.fsm = FCD_S_NEXT;
          end
        end
      end
      FCD_S_NEXT: begin
        st_nxt.fsm = FCD_S_IDLE;
        st_nxt.rr  = st_r.cur + CW'(1);
        if (st_r.ch[st_r.cur].blk_left == 17'h00000) begin
          if (st_r.ch[st_r.cur].rep_left == 9'h001) begin
            // transaction complete
            st_nxt.ch[st_r.cur].active   = 1'b0;
            st_nxt.ch[st_r.cur].pend     = 1'b0;
            st_nxt.ch[st_r.cur].done     = 1'b1;
            st_nxt.ch[st_r.cur].rep_left = 9'h000;
            if (cfg_i[st_r.cur].reload) begin
              st_nxt.ch[st_r.cur].src = cfg_i[st_r.cur].src_addr;
              st_nxt.ch[st_r.cur].dst = cfg_i[st_r.cur].dst_addr;
            end
            // hand over to the paired channel, which must be configured already
            if (cfg_i[st_r.cur].link && !st_r.ch[partner].active) begin
              st_nxt.ch[partner].active   = 1'b1;
              st_nxt.ch[partner].pend     = 1'b0;
              st_nxt.ch[partner].blk_left = {cfg_i[partner].blk_size == 16'h0000,
                                             cfg_i[partner].blk_size};
              st_nxt.ch[partner].rep_left = {cfg_i[partner].rep_cnt == 8'h00,
                                             cfg_i[partner].rep_cnt};
            end
          end else begin
            // next block of the same transaction, addresses carry on
            st_nxt.ch[st_r.cur].rep_left = st_r.ch[st_r.cur].rep_left - 9'h001;
            st_nxt.ch[st_r.cur].blk_left = {cfg_i[st_r.cur].blk_size == 16'h0000,
                                            cfg_i[st_r.cur].blk_size};
          end
        end
      end
      FCD_S_ABORT: begin
        // buffer is flushed this cycle; channel stops with its error flag
        st_nxt.ch[st_r.cur].active = 1'b0;
        st_nxt.ch[st_r.cur].pend   = 1'b0;
        st_nxt.ch[st_r.cur].err    = 1'b1;
        st_nxt.rr                  = st_r.cur + CW'(1);
        st_nxt.fsm                 = FCD_S_IDLE;
      end
      default: begin
        st_nxt.fsm = FCD_S_IDLE;
      end
    endcase

    // triggers last, so one arriving as the previous is consumed is kept
    for (int c = 0; c < NCH; c++) begin
      hw_trig = (int'(cfg_i[c].trig_sel) < NTRIG)
              && trig_i[cfg_i[c].trig_sel]
              && TRIG_AVAIL[c*NTRIG + int'(cfg_i[c].trig_sel)];
      if (st_nxt.ch[c].active && (hw_trig || sw_trig_i[c])) begin
        st_nxt.ch[c].pend = 1'b1;
      end
    end

    // interrupt request follows done flags gated by each channel's enable
    st_nxt.irq = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      st_nxt.irq = st_nxt.irq || (st_nxt.ch[c].done && cfg_i[c].irq_en);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_r     <= '0;
      st_r.fsm <= FCD_S_IDLE;
      for (int c = 0; c < NCH; c++) begin
        st_r.ch[c].src      <= FCD_RST_ADDR;
        st_r.ch[c].dst      <= FCD_RST_ADDR;
        st_r.ch[c].blk_left <= FCD_RST_BLK;
        st_r.ch[c].rep_left <= FCD_RST_REP;
      end
    end else begin
      st_r <= st_nxt;
    end
  end

  // status outputs straight from the state flops
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      active_o[c] = st_r.ch[c].active;
      done_o[c]   = st_r.ch[c].done;
      err_o[c]    = st_r.ch[c].err;
    end
  end

  assign busy_o = (st_r.fsm != FCD_S_IDLE);
  assign irq_o  = st_r.irq;
endmodule // fcd_transfer_controller

// file: verif/fcd_mem.sv
// Purpose: memories and mapped registers on the far side of the shared bus
// Assumes: answer in the request cycle unless stalled
// Notes: idle read data is the inverse of the last byte, never a held copy
`timescale 1ns/1ps
module fcd_mem
  import fcd_pkg::*;
(
  input  wire logic         clk_i,
  input  wire fcd_bus_req_s bus_i,
  input  wire logic         stall_i,
  output logic              ack_o,
  output logic [7:0]        rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'hA5;

  // address pattern makes every moved byte traceable
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = 8'(a) ^ 8'(a >> 8);
    end
  end

  // memory and register space answer alike on the one shared bus
  assign ack_o   = bus_i.valid & ~stall_i;
  assign rdata_o = (ack_o && !bus_i.we) ? mem[bus_i.addr] : ~last_r;

  // writes land on the answering edge
  always @(posedge clk_i) begin
    if (ack_o && bus_i.we) begin
      mem[bus_i.addr] <= bus_i.wdata;
    end else if (ack_o) begin
      last_r <= mem[bus_i.addr];
    end
  end
endmodule // fcd_mem

// file: verif/fcd_transfer_controller_assertions.sv
// Purpose: port level checks of the transfer_controller
// Assumes: default region parameters, one clock domain
// Notes: bound into every instance of the top module
`timescale 1ns/1ps
module fcd_chk
  import fcd_pkg::*;
#(
  parameter int NCH   = FCD_NCH,
  parameter int NTRIG = FCD_NTRIG
) (
  input wire logic               clk_i,
  input wire logic               srst_i,
  input wire fcd_cfg_s [NCH-1:0] cfg_i,
  input wire logic [NCH-1:0]     addr_load_i,
  input wire logic [NCH-1:0]     start_i,
  input wire logic [NCH-1:0]     abort_i,
  input wire logic [NCH-1:0]     sw_trig_i,
  input wire logic [NTRIG-1:0]   trig_i,
  input wire logic [NCH-1:0]     flag_clr_i,
  input wire logic               rr_mode_i,
  input wire logic               cpu_req_i,
  input wire fcd_bus_req_s       bus_o,
  input wire logic               bus_ack_i,
  input wire logic [7:0]         bus_rdata_i,
  input wire logic [NCH-1:0]     active_o,
  input wire logic [NCH-1:0]     done_o,
  input wire logic [NCH-1:0]     err_o,
  input wire logic               busy_o,
  input wire logic               irq_o
);
  logic [NCH-1:0] ien;
  logic [3:0]     rd_run_r;
  logic [3:0]     rd_run_nxt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // interrupt enables pulled out of the config
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ien[c] = cfg_i[c].irq_en;
    end
  end

  // reads in one busy stretch; cleared in idle so an abort cannot pile up
  always_comb begin
    rd_run_nxt = rd_run_r;
    if (!busy_o) begin
      rd_run_nxt = 4'h0;
    end else if (bus_o.valid && bus_ack_i && !bus_o.we) begin
      rd_run_nxt = rd_run_r + 4'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_run_r <= 4'h0;
    end else begin
      rd_run_r <= rd_run_nxt;
    end
  end

  a_cpu_wins_bus: assert property (cpu_req_i |-> !bus_o.valid)
    else $error("engine drove the bus while the processor held it");
  a_stall_holds: assert property (bus_o.valid && !bus_ack_i |=> cpu_req_i ||
    (bus_o.valid && $stable(bus_o.addr) && $stable(bus_o.we) && $stable(bus_o.wdata)))
    else $error("request changed before it was answered");
  a_valid_busy: assert property (bus_o.valid |-> busy_o)
    else $error("bus request outside a burst");
  a_no_prog: assert property (bus_o.valid |-> !(bus_o.addr >= FCD_PROG_BASE && bus_o.addr <= FCD_PROG_LAST))
    else $error("access to program space");
  a_no_nvm_wr: assert property (bus_o.valid && bus_o.we |-> bus_o.addr < FCD_NVM_BASE || bus_o.addr > FCD_NVM_LAST)
    else $error("write into non volatile space");
  a_err_stops: assert property (((err_o & ~$past(err_o)) & active_o) == '0)
    else $error("channel still active after a refused access");
  a_start_arms: assert property (|(start_i & ~active_o) |=> (($past(start_i) & ~$past(active_o)) & ~active_o) == '0)
    else $error("start did not arm the channel");
  a_done_sticky: assert property (1'b1 |=> (($past(done_o) & ~$past(flag_clr_i)) & ~done_o) == '0)
    else $error("done flag fell without a clear");
  a_irq_follows: assert property (1'b1 |=> irq_o == |(done_o & $past(ien)))
    else $error("interrupt does not follow enabled done flags");
  a_burst_max: assert property (rd_run_r <= 4'h8)
    else $error("burst read more than eight bytes");

  c_stall: cover property (bus_o.valid && !bus_ack_i);
  c_err: cover property (|err_o);
  c_irq: cover property (irq_o);
  c_cpu_busy: cover property (cpu_req_i && busy_o);
endmodule // fcd_chk

bind fcd_transfer_controller fcd_chk #(.NCH(NCH), .NTRIG(NTRIG)) i_chk (.clk_i(clk_i), .srst_i(srst_i),
  .cfg_i(cfg_i), .addr_load_i(addr_load_i), .start_i(start_i), .abort_i(abort_i), .sw_trig_i(sw_trig_i),
  .trig_i(trig_i), .flag_clr_i(flag_clr_i), .rr_mode_i(rr_mode_i), .cpu_req_i(cpu_req_i), .bus_o(bus_o),
  .bus_ack_i(bus_ack_i), .bus_rdata_i(bus_rdata_i), .active_o(active_o), .done_o(done_o), .err_o(err_o),
  .busy_o(busy_o), .irq_o(irq_o));

// file: verif/tb.sv
// Purpose: directed scenarios for the four channel transfer_controller
// Assumes: far side model answers at once unless stalled
// Notes: every wait is bounded and counts a mismatch when it runs out
`timescale 1ns/1ps
module tb;
  import fcd_pkg::*;
  logic           clk_i = 1'b0;
  logic           srst_i = 1'b1;
  fcd_cfg_s [3:0] cfg = '0;
  logic [3:0]     ld = '0, st = '0, ab = '0, sw = '0, clr = '0;
  logic [15:0]    trig = '0;
  logic           rr = 1'b0, cpu = 1'b0, stall = 1'b0;
  fcd_bus_req_s   bus;
  logic           ack, busy, irq;
  logic [7:0]     rdata;
  logic [3:0]     act, done, err;
  logic [15:0]    a;
  int             n_fail = 0, compares = 0;

  fcd_transfer_controller i_dut (.clk_i(clk_i), .srst_i(srst_i), .cfg_i(cfg), .addr_load_i(ld), .start_i(st),
    .abort_i(ab), .sw_trig_i(sw), .trig_i(trig), .flag_clr_i(clr), .rr_mode_i(rr), .cpu_req_i(cpu),
    .bus_o(bus), .bus_ack_i(ack), .bus_rdata_i(rdata), .active_o(act), .done_o(done), .err_o(err),
    .busy_o(busy), .irq_o(irq));
  fcd_mem i_mem (.clk_i(clk_i), .bus_i(bus), .stall_i(stall), .ack_o(ack), .rdata_o(rdata));

  // 250 MHz
  initial begin
    forever #2 clk_i = ~clk_i;
  end

  function automatic logic [15:0] pat(input logic [15:0] x);
    return 16'(x[7:0] ^ x[15:8]);
  endfunction

  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // bounded waits; running out ends the run
  task automatic wait_busy(input logic v);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (busy === v) return;
    end
    chk("busy wait", 16'h0, 16'h1);
    tally_and_finish();
  endtask
  task automatic rd_addr(output logic [15:0] x);
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_i);
      if (bus.valid === 1'b1 && bus.we === 1'b0) break;
    end
    x = bus.addr;
    if (bus.valid === 1'b1 && bus.we === 1'b0) begin
      wait_busy(1'b0);
    end else begin
      chk("read wait", 16'h0, 16'h1);
      tally_and_finish();
    end
  endtask

  // trigger field 5 on every channel; f = reload, link, irq enable
  task automatic setc(input int c, input logic [15:0] s, d, b, input logic [7:0] r,
                      input fcd_amode_e sm, dm, input fcd_burst_e bl, input logic [2:0] f);
    @(posedge clk_i);
    cfg[c] <= '{s, d, b, r, sm, dm, bl, f[2], f[1], f[0], 4'h5};
  endtask
  task automatic pulse(input logic [3:0] l, s, x, c, t);
    @(posedge clk_i);
    ld <= l;
    st <= s;
    ab <= x;
    clr <= c;
    sw <= t;
    @(posedge clk_i);
    ld <= '0;
    st <= '0;
    ab <= '0;
    clr <= '0;
    sw <= '0;
  endtask
  // n bursts, one trigger each, each run to idle
  task automatic fire(input logic [3:0] s, input logic [15:0] h, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      sw <= s;
      trig <= h;
      @(posedge clk_i);
      sw <= '0;
      trig <= '0;
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
  endtask

  task automatic t_basic();
    setc(0, 16'h2010, 16'h3000, 16'h4, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_4, 3'h1);
    pulse(4'h1, 4'h1, 4'h0, 4'h0, 4'h0);
    @(posedge clk_i);
    stall <= 1'b1;
    cpu <= 1'b1;
    sw <= 4'h1;
    @(posedge clk_i);
    sw <= 4'h0;
    repeat (8) @(posedge clk_i);
    chk("held off", i_mem.mem[16'h3000], pat(16'h3000));
    cpu <= 1'b0;
    repeat (4) @(posedge clk_i);
    stall <= 1'b0;
    fire(4'h0, 16'h0, 0);
    wait_busy(1'b0);
    for (int i = 0; i < 5; i++) begin
      chk("basic byte", i_mem.mem[16'h3000 + i], pat(16'(i < 4 ? 16'h2010 + i : 16'h3004)));
    end
    @(negedge clk_i);
    chk("done irq", {done[0], irq}, 16'h3);
    pulse(4'h0, 4'h0, 4'h0, 4'h1, 4'h0);
    @(negedge clk_i);
    chk("cleared", {done[0], irq}, 16'h0);
    $display("test basic done");
  endtask

  task automatic t_reload();
    setc(1, 16'h20A3, 16'h3100, 16'h3, 8'h1, FCD_AM_DEC, FCD_AM_FIXED, FCD_BL_1, 3'h4);
    pulse(4'h2, 4'h2, 4'h0, 4'h0, 4'h0);
    fire(4'h2, 16'h0, 3);
    chk("fixed dst", i_mem.mem[16'h3100], pat(16'h20A1));
    chk("dst neighbour", i_mem.mem[16'h3101], pat(16'h3101));
    pulse(4'h0, 4'h2, 4'h0, 4'h2, 4'h0);
    fire(4'h2, 16'h0, 3);
    chk("reloaded run", {i_mem.mem[16'h3100], 7'h0, done[1]}, {8'(pat(16'h20A1)), 8'h1});
    $display("test reload done");
  endtask

  task automatic t_repeat();
    setc(2, 16'h2040, 16'h3200, 16'h2, 8'h3, FCD_AM_INC, FCD_AM_INC, FCD_BL_8, 3'h0);
    pulse(4'h4, 4'h4, 4'h0, 4'h0, 4'h0);
    fire(4'h0, 16'h0020, 2);
    chk("early done", done[2], 16'h0);
    fire(4'h0, 16'h0020, 1);
    chk("repeat done", done[2], 16'h1);
    for (int i = 0; i < 7; i++) begin
      chk("repeat byte", i_mem.mem[16'h3200 + i], pat(16'(i < 6 ? 16'h2040 + i : 16'h3206)));
    end
    $display("test repeat done");
  endtask

  task automatic t_link();
    setc(0, 16'h2050, 16'h3300, 16'h1, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h2);
    setc(1, 16'h2060, 16'h3310, 16'h1, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h0);
    pulse(4'h3, 4'h1, 4'h0, 4'h3, 4'h0);
    fire(4'h1, 16'h0, 1);
    chk("partner armed", act[1], 16'h1);
    fire(4'h2, 16'h0, 1);
    chk("link bytes", {i_mem.mem[16'h3300], i_mem.mem[16'h3310]}, {8'(pat(16'h2050)), 8'(pat(16'h2060))});
    $display("test link done");
  endtask

  task automatic t_err();
    setc(3, 16'h2070, 16'h1004, 16'h1, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h0);
    pulse(4'h8, 4'h8, 4'h0, 4'h0, 4'h0);
    fire(4'h8, 16'h0, 1);
    chk("nvm refused", {err[3], act[3], i_mem.mem[16'h1004]}, {2'h2, 8'(pat(16'h1004))});
    setc(3, 16'hF010, 16'h3400, 16'h1, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h0);
    pulse(4'h8, 4'h8, 4'h0, 4'h8, 4'h0);
    fire(4'h8, 16'h0, 1);
    chk("prog refused", {err[3], act[3], i_mem.mem[16'h3400]}, {2'h2, 8'(pat(16'h3400))});
    pulse(4'h0, 4'h8, 4'h0, 4'h8, 4'h0);
    @(negedge clk_i);
    chk("armed", act[3], 16'h1);
    pulse(4'h0, 4'h0, 4'h8, 4'h0, 4'h0);
    @(negedge clk_i);
    chk("aborted", act[3], 16'h0);
    $display("test err done");
  endtask

  task automatic t_prio();
    setc(0, 16'h2080, 16'h3500, 16'h3, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h0);
    setc(1, 16'h2090, 16'h3510, 16'h3, 8'h1, FCD_AM_INC, FCD_AM_INC, FCD_BL_1, 3'h0);
    pulse(4'h3, 4'h3, 4'h0, 4'h3, 4'h3);
    rd_addr(a);
    chk("fixed first", a, 16'h2080);
    rd_addr(a);
    chk("fixed second", a, 16'h2090);
    fire(4'h1, 16'h0, 1);
    @(posedge clk_i);
    rr <= 1'b1;
    sw <= 4'h3;
    @(posedge clk_i);
    sw <= 4'h0;
    rd_addr(a);
    chk("rotated first", a, 16'h2091);
    rd_addr(a);
    chk("rotated second", a, 16'h2082);
    $display("test prio done");
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("after reset", 16'({act, done, err, busy, irq, bus.valid}), 16'h0);
    t_basic();
    t_reload();
    t_repeat();
    t_link();
    t_err();
    t_prio();
    tally_and_finish();
  end
endmodule // tb
